/* rtl/mdf_defines.svh */
`ifndef MDF_DEFINES_SVH
`define MDF_DEFINES_SVH

// Control and marker characters of the multi-drop link.
`define MDF_CH_AT 8'h40
`define MDF_CH_STX 8'h02
`define MDF_CH_ETX 8'h03
`define MDF_CH_ETB 8'h17
`define MDF_CH_ACK 8'h06
`define MDF_CH_NAK 8'h15
`define MDF_CH_SPACE 8'h20
`define MDF_CH_OK 8'h23
`define MDF_CH_FAIL 8'h21
`define MDF_CH_ZERO 8'h30
`define MDF_CH_ONE 8'h31

// Checksum seed, block limits and retry limit.
`define MDF_LRC_INIT 8'hFF
`define MDF_MAX_MSG 255
`define MDF_MAX_RETRY 5
`define MDF_STATION_MAX 7'h7F
`define MDF_FIRST_BLOCK 10'h001

// Result position and block lengths of a response block.
`define MDF_POS_RESULT 5'h07
`define MDF_LEN_OK 5'h0A
`define MDF_LEN_FAIL 5'h0D

`endif

/* rtl/mdf_framer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mdf_defines.svh"

// Functional notes
// - Every block opens with '@' then two station digits before STX.
// - Station number 1 to 127, sent as upper-case hex ASCII digits.
// - Order: '@', station, STX, three-digit block number, message, end, checksum.
// - Single-block frame uses number 001, STX first and ETX before checksum.
// - Non-final blocks carry exactly 255 characters, end in ETB, count from 001.
// - Final block carries the rest, numbered with block count, ends in ETX.
// - Parameters are 16-bit signed values written as hex ASCII characters.
// - Space and function code appear only in the first block.
// - Unit answers '#' on success, or '!' plus three code characters.
// - After acking the final block, execute, then send response block 001.
// - Host sends block 002 only after the unit acked block 001.
// - Checksum starts at FF and XORs every byte from STX to the end character.
// - On NAK the sender repeats the same frame, at most five times.
module mdf_framer #(
  parameter int MAX_MSG = `MDF_MAX_MSG,
  parameter int MAX_RETRY = `MDF_MAX_RETRY
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [6:0] station_pin,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output mdf_pkg::mdf_msg_s msg,
  output logic blk_ok,
  output logic blk_bad,
  output logic cmd_exec,
  input wire logic res_valid,
  input wire mdf_pkg::mdf_result_s res,
  output logic retry_fail,
  output logic station_ok
);

  logic [6:0] station_meta;
  logic [6:0] station;
  mdf_pkg::mdf_rx_e rx_st;
  mdf_pkg::mdf_ctl_e ctl_st;
  logic take;
  logic [4:0] hex;
  logic [3:0] st_hi;
  logic [1:0] bn_idx;
  logic [9:0] bn_val;
  logic [9:0] exp_bn;
  logic [8:0] msg_cnt;
  logic err;
  logic end_etb;
  logic ans_nak;
  logic blk_done;
  logic blk_good;
  logic blk_etb;
  logic ans_evt;
  logic ans_is_nak;
  logic lrc_load;
  logic lrc_en;
  logic [7:0] lrc;
  logic tx_start;
  mdf_pkg::mdf_tx_e tx_kind;
  logic tx_done;
  mdf_pkg::mdf_result_s res_q;
  logic exec_pending;
  logic [2:0] retry;
  logic accepting;

  // Station strap pins come from outside and pass two flip-flops.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      station_meta <= 7'h00;
      station <= 7'h00;
      station_ok <= 1'b0;
    end else if (ce) begin
      station_meta <= station_pin;
      station <= station_meta;
      station_ok <= (station != 7'h00) && (station <= `MDF_STATION_MAX);
    end
  end

  // A block is started on '@' only while the link is ours to listen on.
  assign accepting = (ctl_st == mdf_pkg::C_IDLE) || (ctl_st == mdf_pkg::C_WAIT);
  assign take = ce && rx_valid;
  assign hex = mdf_pkg::mdf_from_hex(rx_data);

  // Checksum runs from STX through the end character.
  assign lrc_load = take && (rx_st == mdf_pkg::R_STX) && (rx_data == `MDF_CH_STX);
  assign lrc_en = take && ((rx_st == mdf_pkg::R_BN) || (rx_st == mdf_pkg::R_MSG));

  mdf_lrc u_lrc (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .load(lrc_load),
    .en(lrc_en),
    .data(rx_data),
    .lrc(lrc)
  );

  // Receive parser walks one block byte by byte.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_st <= mdf_pkg::R_IDLE;
      st_hi <= 4'h0;
      bn_idx <= 2'h0;
      bn_val <= 10'h000;
      msg_cnt <= 9'h000;
      err <= 1'b0;
      end_etb <= 1'b0;
      ans_nak <= 1'b0;
    end else if (take) begin
      case (rx_st)
        mdf_pkg::R_IDLE: begin
          if (rx_data == `MDF_CH_AT && accepting) begin
            rx_st <= mdf_pkg::R_ST_HI;
          end else if ((rx_data == `MDF_CH_ACK || rx_data == `MDF_CH_NAK) && ctl_st == mdf_pkg::C_WAIT) begin
            ans_nak <= (rx_data == `MDF_CH_NAK);
            rx_st <= mdf_pkg::R_AN_HI;
          end
        end
        mdf_pkg::R_ST_HI, mdf_pkg::R_AN_HI: begin
          st_hi <= hex[3:0];
          if (hex[4]) begin
            rx_st <= (rx_st == mdf_pkg::R_ST_HI) ? mdf_pkg::R_ST_LO : mdf_pkg::R_AN_LO;
          end else begin
            rx_st <= mdf_pkg::R_IDLE;
          end
        end
        mdf_pkg::R_ST_LO: begin
          if (hex[4] && station_ok && {st_hi, hex[3:0]} == {1'b0, station}) begin
            rx_st <= mdf_pkg::R_STX;
          end else begin
            rx_st <= mdf_pkg::R_IDLE;
          end
        end
        mdf_pkg::R_AN_LO: begin
          rx_st <= mdf_pkg::R_IDLE;
        end
        mdf_pkg::R_STX: begin
          bn_idx <= 2'h0;
          bn_val <= 10'h000;
          msg_cnt <= 9'h000;
          err <= 1'b0;
          rx_st <= (rx_data == `MDF_CH_STX) ? mdf_pkg::R_BN : mdf_pkg::R_IDLE;
        end
        mdf_pkg::R_BN: begin
          if (rx_data < `MDF_CH_ZERO || rx_data > 8'h39) begin
            err <= 1'b1;
          end
          bn_val <= 10'((bn_val << 3) + (bn_val << 1) + {6'h00, rx_data[3:0]});
          bn_idx <= bn_idx + 2'h1;
          if (bn_idx == 2'h2) begin
            rx_st <= mdf_pkg::R_MSG;
          end
        end
        mdf_pkg::R_MSG: begin
          if (rx_data == `MDF_CH_ETX || rx_data == `MDF_CH_ETB) begin
            end_etb <= (rx_data == `MDF_CH_ETB);
            rx_st <= mdf_pkg::R_LRC;
          end else if (msg_cnt == 9'(MAX_MSG)) begin
            err <= 1'b1;
          end else begin
            msg_cnt <= msg_cnt + 9'h001;
          end
        end
        mdf_pkg::R_LRC: begin
          rx_st <= mdf_pkg::R_IDLE;
        end
        default: begin
          rx_st <= mdf_pkg::R_IDLE;
        end
      endcase
    end
  end

  // Block verdict: checksum, number sequence and block length.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_done <= 1'b0;
      blk_good <= 1'b0;
      blk_etb <= 1'b0;
      ans_evt <= 1'b0;
      ans_is_nak <= 1'b0;
    end else if (ce) begin
      blk_done <= take && rx_st == mdf_pkg::R_LRC;
      blk_etb <= end_etb;
      blk_good <= (rx_data == lrc) && !err
                  && (bn_val == exp_bn || bn_val == `MDF_FIRST_BLOCK)
                  && (!end_etb || msg_cnt == 9'(MAX_MSG));
      ans_evt <= take && rx_st == mdf_pkg::R_AN_LO && hex[4]
                 && {st_hi, hex[3:0]} == {1'b0, station};
      ans_is_nak <= ans_nak;
    end
  end

  // Expected block number climbs on each good ETB block.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_bn <= `MDF_FIRST_BLOCK;
    end else if (ce && blk_done && blk_good) begin
      exp_bn <= blk_etb ? exp_bn + 10'h001 : `MDF_FIRST_BLOCK;
    end
  end

  // Message characters stream to the executor as they arrive.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg <= '0;
    end else if (ce) begin
      msg.valid <= take && rx_st == mdf_pkg::R_MSG && rx_data != `MDF_CH_ETX
                   && rx_data != `MDF_CH_ETB && msg_cnt != 9'(MAX_MSG);
      msg.first <= take && rx_st == mdf_pkg::R_MSG && rx_data != `MDF_CH_ETX && rx_data != `MDF_CH_ETB
                   && (bn_val == `MDF_FIRST_BLOCK) && (msg_cnt == 9'h000);
      msg.data <= rx_data;
    end
  end

  // Block control: acknowledge, execute, respond and retry.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_st <= mdf_pkg::C_IDLE;
      tx_start <= 1'b0;
      tx_kind <= mdf_pkg::T_ACK;
      exec_pending <= 1'b0;
      res_q <= '0;
      retry <= 3'h0;
      blk_ok <= 1'b0;
      blk_bad <= 1'b0;
      cmd_exec <= 1'b0;
      retry_fail <= 1'b0;
    end else if (ce) begin
      tx_start <= 1'b0;
      blk_ok <= 1'b0;
      blk_bad <= 1'b0;
      cmd_exec <= 1'b0;
      retry_fail <= 1'b0;
      case (ctl_st)
        mdf_pkg::C_IDLE, mdf_pkg::C_WAIT: begin
          if (blk_done) begin
            tx_start <= 1'b1;
            tx_kind <= blk_good ? mdf_pkg::T_ACK : mdf_pkg::T_NAK;
            blk_ok <= blk_good;
            blk_bad <= !blk_good;
            exec_pending <= blk_good && !blk_etb;
            ctl_st <= mdf_pkg::C_ACKW;
          end else if (ctl_st == mdf_pkg::C_WAIT && ans_evt) begin
            if (!ans_is_nak) begin
              ctl_st <= mdf_pkg::C_IDLE;
            end else if (retry == 3'(MAX_RETRY)) begin
              retry_fail <= 1'b1;
              ctl_st <= mdf_pkg::C_IDLE;
            end else begin
              retry <= retry + 3'h1;
              tx_start <= 1'b1;
              tx_kind <= mdf_pkg::T_RESP;
              ctl_st <= mdf_pkg::C_RESP;
            end
          end
        end
        mdf_pkg::C_ACKW: begin
          if (tx_done) begin
            cmd_exec <= exec_pending;
            ctl_st <= exec_pending ? mdf_pkg::C_EXEC : mdf_pkg::C_IDLE;
          end
        end
        mdf_pkg::C_EXEC: begin
          if (res_valid) begin
            res_q <= res;
            retry <= 3'h0;
            tx_start <= 1'b1;
            tx_kind <= mdf_pkg::T_RESP;
            ctl_st <= mdf_pkg::C_RESP;
          end
        end
        mdf_pkg::C_RESP: begin
          if (tx_done) begin
            ctl_st <= mdf_pkg::C_WAIT;
          end
        end
        default: begin
          ctl_st <= mdf_pkg::C_IDLE;
        end
      endcase
    end
  end

  mdf_tx u_tx (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(tx_start),
    .kind(tx_kind),
    .station(station),
    .res(res_q),
    .tx_ready(tx_ready),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .done(tx_done)
  );

endmodule : mdf_framer
`default_nettype wire

/* rtl/mdf_lrc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mdf_defines.svh"

module mdf_lrc (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic load,
  input wire logic en,
  input wire logic [7:0] data,
  output logic [7:0] lrc
);

  // Load seeds the sum with the opening byte; en folds in each later byte.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lrc <= `MDF_LRC_INIT;
    end else if (ce && load) begin
      lrc <= `MDF_LRC_INIT ^ data;
    end else if (ce && en) begin
      lrc <= lrc ^ data;
    end
  end

endmodule : mdf_lrc
`default_nettype wire

/* rtl/mdf_pkg.sv */
package mdf_pkg;

  // Receive parser states.
  typedef enum logic [8:0] {
    R_IDLE = 9'h001,
    R_ST_HI = 9'h002,
    R_ST_LO = 9'h004,
    R_STX = 9'h008,
    R_BN = 9'h010,
    R_MSG = 9'h020,
    R_LRC = 9'h040,
    R_AN_HI = 9'h080,
    R_AN_LO = 9'h100
  } mdf_rx_e;

  // Block-level control states.
  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_ACKW = 5'h02,
    C_EXEC = 5'h04,
    C_RESP = 5'h08,
    C_WAIT = 5'h10
  } mdf_ctl_e;

  // Kinds of transmission the sender makes.
  typedef enum logic [2:0] {
    T_ACK = 3'h1,
    T_NAK = 3'h2,
    T_RESP = 3'h4
  } mdf_tx_e;

  // Result handed back by the command executor.
  typedef struct packed {
    logic ok;
    logic [23:0] code;
  } mdf_result_s;

  // Message character delivered to the command executor.
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } mdf_msg_s;

  // Upper-case hexadecimal digit of a nibble.
  function automatic logic [7:0] mdf_to_hex(input logic [3:0] n);
    mdf_to_hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : mdf_to_hex

  // Nibble of an upper-case hexadecimal digit, with a valid flag on top.
  function automatic logic [4:0] mdf_from_hex(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) begin
      mdf_from_hex = {1'b1, c[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      mdf_from_hex = {1'b1, c[3:0] + 4'h9};
    end else begin
      mdf_from_hex = 5'h00;
    end
  endfunction : mdf_from_hex

endpackage : mdf_pkg

/* rtl/mdf_tx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mdf_defines.svh"

module mdf_tx (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic start,
  input wire mdf_pkg::mdf_tx_e kind,
  input wire logic [6:0] station,
  input wire mdf_pkg::mdf_result_s res,
  input wire logic tx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic done
);

  logic [4:0] idx;
  logic [4:0] last;
  logic [7:0] lrc_acc;
  logic [7:0] next_lrc;
  logic [7:0] next_byte;

  // Byte of the response block at the position after the current one.
  always_comb begin
    next_lrc = lrc_acc ^ tx_data;
    case (idx + 5'h01)
      5'h01: next_byte = mdf_pkg::mdf_to_hex({1'b0, station[6:4]});
      5'h02: next_byte = mdf_pkg::mdf_to_hex(station[3:0]);
      5'h03: next_byte = `MDF_CH_STX;
      5'h04: next_byte = `MDF_CH_ZERO;
      5'h05: next_byte = `MDF_CH_ZERO;
      5'h06: next_byte = `MDF_CH_ONE;
      5'h07: next_byte = res.ok ? `MDF_CH_OK : `MDF_CH_FAIL;
      5'h08: next_byte = res.ok ? `MDF_CH_ETX : res.code[23:16];
      5'h09: next_byte = res.ok ? next_lrc : res.code[15:8];
      5'h0A: next_byte = res.code[7:0];
      5'h0B: next_byte = `MDF_CH_ETX;
      default: next_byte = next_lrc;
    endcase
  end

  // Serialiser: one byte per accepted handshake, last byte drops valid.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      idx <= 5'h00;
      last <= 5'h00;
      lrc_acc <= `MDF_LRC_INIT;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !tx_valid) begin
        tx_valid <= 1'b1;
        idx <= 5'h00;
        lrc_acc <= `MDF_LRC_INIT;
        case (kind)
          mdf_pkg::T_ACK: begin
            tx_data <= `MDF_CH_ACK;
            last <= 5'h00;
          end
          mdf_pkg::T_NAK: begin
            tx_data <= `MDF_CH_NAK;
            last <= 5'h00;
          end
          default: begin
            tx_data <= `MDF_CH_AT;
            last <= (res.ok ? `MDF_LEN_OK : `MDF_LEN_FAIL) - 5'h01;
          end
        endcase
      end else if (tx_valid && tx_ready) begin
        if (idx == last) begin
          tx_valid <= 1'b0;
          done <= 1'b1;
        end else begin
          idx <= idx + 5'h01;
          tx_data <= next_byte;
          if (idx >= 5'h03) begin
            lrc_acc <= next_lrc;
          end
        end
      end
    end
  end

endmodule : mdf_tx
`default_nettype wire

/* sim/mdf_framer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mdf_framer_sva #(
  parameter int MAX_MSG = 255,
  parameter int MAX_RETRY = 5
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [6:0] station_pin,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire mdf_pkg::mdf_msg_s msg,
  input wire logic blk_ok,
  input wire logic blk_bad,
  input wire logic cmd_exec,
  input wire logic res_valid,
  input wire mdf_pkg::mdf_result_s res,
  input wire logic retry_fail,
  input wire logic station_ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A transmitted byte offered on the link.
  sequence s_out(logic [7:0] b);
    tx_valid && tx_data == b;
  endsequence
  // The result taken at the edge where the execute pulse is seen.
  sequence s_taken;
    cmd_exec && res_valid;
  endsequence

  property p_ack;
    blk_ok |=> s_out(8'h06);
  endproperty
  a_ack: assert property (p_ack) else $error("accepted block not answered with ACK");
  property p_nak;
    blk_bad |=> s_out(8'h15);
  endproperty
  a_nak: assert property (p_nak) else $error("rejected block not answered with NAK");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped before handshake");
  property p_resp;
    s_taken |-> ##1 !tx_valid ##1 s_out(8'h40);
  endproperty
  a_resp: assert property (p_resp) else $error("response does not open with marker");
  property p_excl;
    blk_ok |-> !blk_bad && !cmd_exec;
  endproperty
  a_excl: assert property (p_excl) else $error("ack pulse overlaps reject or execute");
  property p_station;
    ($stable(station_pin) && rst_b) [*5] |-> station_ok == (station_pin != 7'h00);
  endproperty
  a_station: assert property (p_station) else $error("station valid flag wrong");
  property p_fail;
    retry_fail |=> (!tx_valid) [*4];
  endproperty
  a_fail: assert property (p_fail) else $error("resend after retry limit");
  property p_first;
    msg.first |-> msg.valid;
  endproperty
  a_first: assert property (p_first) else $error("first flag without character");
endmodule : mdf_framer_sva

bind mdf_framer mdf_framer_sva #(.MAX_MSG(MAX_MSG), .MAX_RETRY(MAX_RETRY)) u_sva (.clk(clk), .rst_b(rst_b),
  .ce(ce), .station_pin(station_pin), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
  .tx_valid(tx_valid), .tx_data(tx_data), .msg(msg), .blk_ok(blk_ok), .blk_bad(blk_bad), .cmd_exec(cmd_exec),
  .res_valid(res_valid), .res(res), .retry_fail(retry_fail), .station_ok(station_ok));
`default_nettype wire

/* sim/mdf_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mdf_host (
  input wire logic clk,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  logic [7:0] sendq[$];
  logic [7:0] txq[$];
  logic slow = 1'b0;

  // Upper-case hex digit of a nibble.
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hx

  // Idle values at time zero.
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end

  // Sends queued bytes back to back; an idle line shows a changing pattern.
  always @(posedge clk) begin
    if (sendq.size() != 0) begin
      rx_valid <= 1'b1;
      rx_data <= sendq.pop_front();
    end else begin
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
    end
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      txq.push_back(tx_data);
    end
  end

  // Queues one block: marker, station, start, number, message, end, checksum.
  task automatic blk(input logic [6:0] st, input logic [7:0] bn, input int n, input logic [7:0] endc,
                     input logic head, input logic bad);
    logic [7:0] c;
    logic [7:0] lrc;
    lrc = 8'hFF ^ 8'h02 ^ 8'h30 ^ 8'h30 ^ bn ^ endc;
    sendq.push_back(8'h40);
    sendq.push_back(hx({1'b0, st[6:4]}));
    sendq.push_back(hx(st[3:0]));
    sendq.push_back(8'h02);
    sendq.push_back(8'h30);
    sendq.push_back(8'h30);
    sendq.push_back(bn);
    for (int i = 0; i < n; i++) begin
      c = (head && i == 0) ? 8'h20 : (head && i == 1) ? 8'h45 : 8'h30;
      lrc = lrc ^ c;
      sendq.push_back(c);
    end
    sendq.push_back(endc);
    sendq.push_back(bad ? ~lrc : lrc);
  endtask : blk

  // Reply to a response block with ACK or NAK and the station digits.
  task automatic ans(input logic [6:0] st, input logic [7:0] b);
    sendq.push_back(b);
    sendq.push_back(hx({1'b0, st[6:4]}));
    sendq.push_back(hx(st[3:0]));
  endtask : ans
endmodule : mdf_host
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [6:0] ST = 7'h7F;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [6:0] station_pin = ST;
  logic rx_valid, tx_ready, tx_valid, blk_ok, blk_bad, cmd_exec, retry_fail, station_ok;
  logic [7:0] rx_data, tx_data, got;
  mdf_pkg::mdf_msg_s msg;
  logic res_valid = 1'b0;
  mdf_pkg::mdf_result_s res = '0;
  logic [15:0] c_ok = '0, c_bad = '0, c_exec = '0, c_fail = '0, c_first = '0, c_chr = '0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  mdf_framer dut (.clk(clk), .rst_b(rst_b), .ce(ce), .station_pin(station_pin), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .msg(msg), .blk_ok(blk_ok),
    .blk_bad(blk_bad), .cmd_exec(cmd_exec), .res_valid(res_valid), .res(res), .retry_fail(retry_fail),
    .station_ok(station_ok));
  mdf_host host (.clk(clk), .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready));

  always #2 clk = ~clk;

  // Counts pulses and characters; cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    c_ok <= c_ok + 16'(blk_ok);
    c_bad <= c_bad + 16'(blk_bad);
    c_exec <= c_exec + 16'(cmd_exec);
    c_fail <= c_fail + 16'(retry_fail);
    c_first <= c_first + 16'(msg.first);
    c_chr <= c_chr + 16'(msg.valid);
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // Takes the next transmitted byte, waiting a bounded time, and compares it.
  task automatic nextb(input logic [7:0] e);
    for (int i = 0; i < 4000 && host.txq.size() == 0; i++) begin
      @(posedge clk);
    end
    got = (host.txq.size() != 0) ? host.txq.pop_front() : 8'hXX;
    chk({8'h00, got}, {8'h00, e});
  endtask : nextb

  // Lets queued input drain and the block settle.
  task automatic settle();
    for (int i = 0; i < 2000 && host.sendq.size() != 0; i++) begin
      @(posedge clk);
    end
    repeat (40) @(posedge clk);
  endtask : settle

  // Checks one response block for station 7F.
  task automatic resp(input logic ok);
    logic [7:0] l;
    l = 8'hFF ^ 8'h02 ^ 8'h30 ^ 8'h30 ^ 8'h31 ^ 8'h03 ^ (ok ? 8'h23 : 8'h21 ^ 8'h45 ^ 8'h30 ^ 8'h31);
    nextb(8'h40);
    nextb(8'h37);
    nextb(8'h46);
    nextb(8'h02);
    nextb(8'h30);
    nextb(8'h30);
    nextb(8'h31);
    nextb(ok ? 8'h23 : 8'h21);
    if (!ok) begin
      nextb(8'h45);
      nextb(8'h30);
      nextb(8'h31);
    end
    nextb(8'h03);
    nextb(l);
  endtask : resp

  // Single block command with a pass or fail result.
  task automatic t_single(input logic ok);
    res <= {ok, 24'h453031};
    res_valid <= 1'b1;
    host.blk(ST, 8'h31, 6, 8'h03, 1'b1, 1'b0);
    nextb(8'h06);
    resp(ok);
    res_valid <= 1'b0;
    host.ans(ST, 8'h06);
    settle();
  endtask : t_single

  // Corrupted checksum, a wrong block number, another station, then a block sent while ce is low.
  task automatic t_bad();
    host.blk(ST, 8'h31, 4, 8'h03, 1'b1, 1'b1);
    nextb(8'h15);
    settle();
    host.blk(ST, 8'h33, 4, 8'h03, 1'b1, 1'b0);
    nextb(8'h15);
    settle();
    host.blk(7'h7E, 8'h31, 4, 8'h03, 1'b1, 1'b0);
    settle();
    chk(16'(host.txq.size()), 16'h0000);
    ce <= 1'b0;
    host.blk(ST, 8'h31, 4, 8'h03, 1'b1, 1'b0);
    settle();
    ce <= 1'b1;
    repeat (20) @(posedge clk);
    chk(c_chr, 16'h0014);
    chk(16'(host.txq.size()), 16'h0000);
  endtask : t_bad

  // Full ETB block followed by the final block numbered 002.
  task automatic t_multi();
    res <= {1'b1, 24'h453031};
    res_valid <= 1'b1;
    host.blk(ST, 8'h31, 255, 8'h17, 1'b1, 1'b0);
    nextb(8'h06);
    settle();
    chk(c_exec, 16'h0002);
    host.blk(ST, 8'h32, 3, 8'h03, 1'b0, 1'b0);
    nextb(8'h06);
    resp(1'b1);
    res_valid <= 1'b0;
    host.ans(ST, 8'h06);
    settle();
    chk(c_chr, 16'h0116);
    chk(c_first, 16'h0004);
  endtask : t_multi

  // Response refused six times by the host.
  task automatic t_retry();
    res <= {1'b1, 24'h453031};
    res_valid <= 1'b1;
    host.blk(ST, 8'h31, 6, 8'h03, 1'b1, 1'b0);
    nextb(8'h06);
    for (int k = 0; k < 6; k++) begin
      resp(1'b1);
      res_valid <= 1'b0;
      host.ans(ST, 8'h15);
    end
    settle();
    chk(c_fail, 16'h0001);
    chk(16'(host.txq.size()), 16'h0000);
  endtask : t_retry

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (5) @(posedge clk);
    chk({15'h0000, station_ok}, 16'h0001);
    t_single(1'b1);
    host.slow <= 1'b1;
    t_single(1'b0);
    host.slow <= 1'b0;
    t_bad();
    t_multi();
    t_retry();
    chk(c_ok, 16'h0005);
    chk(c_bad, 16'h0002);
    chk(c_exec, 16'h0004);
    results();
  end
endmodule : tb
`default_nettype wire
